// ==== core/swfl_pkg.sv ====
// constants shared by the switch fault latch and its serial port
// Summary of operation
// RULE1 - eight low and two high trip levels per output, one of each watched
// RULE2 - low trip held past the programmed delay latches that output off
// RULE3 - high trip latches the output off at once, no delay
// RULE4 - latched output stays off until its command goes off then on
// RULE5 - guard off: no supply low report, output follows command above reset level
// RULE6 - serial input sampled into the shift register on serial clock fall
// RULE7 - serial output moves to the next bit on serial clock rise
// RULE8 - command and status words travel most significant bit first
// RULE9 - shift path is first-in first-out so words pass through for chaining
// RULE10 - host keeps serial clock low while chip select changes
// RULE11 - chip select high: clock and data ignored, serial output released
// RULE12 - supply recovers with command on: fault flag low, output off until re-command
// RULE13 - supply recovers with command off: fault flag high, low flag kept until read
// RULE14 - faults held, returned in the first valid transfer and cleared by it
// RULE15 - word latched on chip select rise, status loaded on chip select fall
// RULE16 - eight bit words; a transfer not a multiple of eight is ignored
package swfl_pkg;
	localparam int unsigned CMD_BITS = 8;
	localparam int unsigned NUM_OUTPUTS = 2;
	localparam int unsigned LOW_LEVELS = 8;
	localparam int unsigned HIGH_LEVELS = 2;
	localparam int unsigned CLK_PERIOD_PS = 5000;
	// command word fields
	localparam int unsigned F_CHAN = 7;
	localparam int unsigned F_ADDR_LSB = 4;
	localparam logic [2:0] ADDR_OUT_CTRL = 3'h1;
	localparam logic [2:0] ADDR_TRIP_LEVEL = 3'h2;
	localparam logic [2:0] ADDR_TRIP_DELAY = 3'h3;
	localparam logic [2:0] ADDR_SUPPLY = 3'h6;
	localparam int unsigned F_ON0 = 0;
	localparam int unsigned F_ON1 = 2;
	localparam int unsigned F_HIGH_SEL = 3;
	localparam int unsigned F_GUARD_OFF = 1;
	// status word fields
	localparam int unsigned S_LATCHED = 7;
	localparam int unsigned S_SUPPLY_LOW = 6;
	localparam int unsigned S_HIGH_LSB = 4;
	localparam int unsigned S_LOW_LSB = 2;
	localparam int unsigned S_ON_LSB = 0;
	// reset values
	localparam logic [2:0] RST_LOW_SEL = 3'h0;
	localparam logic RST_HIGH_SEL = 1'b0;
	localparam logic [1:0] RST_DELAY_SEL = 2'h0;
	localparam logic RST_GUARD_OFF = 1'b0;
	// low trip delay choices in ns, and their cycle counts rounded up
	localparam int unsigned LOW_TRIP_DELAY_NS [4] = '{2000, 5000, 10000, 20000};
	localparam int unsigned TMR_W = 12;
	localparam logic [TMR_W-1:0] LOW_TRIP_CYC [4] = '{
		TMR_W'((LOW_TRIP_DELAY_NS[0] * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS),
		TMR_W'((LOW_TRIP_DELAY_NS[1] * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS),
		TMR_W'((LOW_TRIP_DELAY_NS[2] * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS),
		TMR_W'((LOW_TRIP_DELAY_NS[3] * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS)};
endpackage

// ==== core/swfl_sync.sv ====
// two flip-flop synchroniser for a vector of pins
`timescale 1ns/1ps
module swfl_sync #(
	parameter int unsigned WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_srst,
	// pins in, synchronised out
	input wire logic [WIDTH-1:0] i_d,
	output logic [WIDTH-1:0] o_q
);
	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] sync_ff;

	// first stage feeds only the second
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			meta_ff <= RST_VAL;
			sync_ff <= RST_VAL;
		end else begin
			meta_ff <= i_d;
			sync_ff <= meta_ff;
		end
	end

	assign o_q = sync_ff;
endmodule

// ==== core/swfl_switch_fault_latch.sv ====
// fault latch, supply guard and serial slave port of a dual high-side switch
`timescale 1ns/1ps
module swfl_switch_fault_latch
	import swfl_pkg::*;
#(
	parameter int unsigned N_OUT = NUM_OUTPUTS
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_srst,
	// serial port pins
	input wire logic i_spi_cs_n,
	input wire logic i_spi_sclk,
	input wire logic i_spi_si,
	output logic o_spi_so,
	output logic o_spi_so_oe,
	// direct output commands
	input wire logic [N_OUT-1:0] i_direct_on,
	// analog comparators: current at or above level k, supply below thresholds
	input wire logic [N_OUT*LOW_LEVELS-1:0] i_low_trip_level,
	input wire logic [N_OUT*HIGH_LEVELS-1:0] i_high_trip_level,
	input wire logic i_supply_low_threshold,
	input wire logic i_supply_reset_threshold,
	// switch drive and flags
	output logic [N_OUT-1:0] o_out_on,
	output logic o_fault_flag_n,
	output logic o_supply_low_flag,
	// latched command word
	output logic [CMD_BITS-1:0] o_cmd_word,
	output logic o_cmd_valid
);
	localparam int unsigned SYNC_W = 5 + N_OUT + N_OUT * LOW_LEVELS + N_OUT * HIGH_LEVELS;

	// the status layout and channel select bit serve exactly two outputs
	if (N_OUT != 2) begin : g_bad_param
		$error("swfl_switch_fault_latch serves exactly two outputs");
	end

	// true when the word addresses the given register
	function automatic logic addr_is(input logic [CMD_BITS-1:0] w, input logic [2:0] a);
		addr_is = (w[F_ADDR_LSB +: 3] == a);
	endfunction

	logic [SYNC_W-1:0] sync_q;
	logic cs_n_s, sclk_s, si_s, supply_low_s, supply_reset_s;
	logic [N_OUT-1:0] direct_s;
	logic [N_OUT*LOW_LEVELS-1:0] low_s;
	logic [N_OUT*HIGH_LEVELS-1:0] high_s;

	// every pin passes two flip-flops; chip select idles high
	swfl_sync #(
		.WIDTH(SYNC_W),
		.RST_VAL({1'b1, {(SYNC_W-1){1'b0}}})
	) u_sync (
		.i_clk(i_clk),
		.i_srst(i_srst),
		.i_d({i_spi_cs_n, i_spi_sclk, i_spi_si, i_supply_low_threshold, i_supply_reset_threshold,
			i_direct_on, i_low_trip_level, i_high_trip_level}),
		.o_q(sync_q)
	);

	assign {cs_n_s, sclk_s, si_s, supply_low_s, supply_reset_s, direct_s, low_s, high_s} = sync_q;

	logic cs_n_q_ff, sclk_q_ff;
	logic sclk_rise, sclk_fall, cs_fall, cs_rise;
	logic [CMD_BITS-1:0] shift_ff;
	logic [2:0] bit_cnt_ff;
	logic got_bits_ff, xfer_ok;
	logic [CMD_BITS-1:0] status_word;

	// previous levels for edge finding
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			cs_n_q_ff <= 1'b1;
			sclk_q_ff <= 1'b0;
		end else begin
			cs_n_q_ff <= cs_n_s;
			sclk_q_ff <= sclk_s;
		end
	end

	// clock edges count only while selected
	assign sclk_rise = sclk_s & ~sclk_q_ff & ~cs_n_s & ~cs_n_q_ff; // [RULE11] [RULE10]
	assign sclk_fall = ~sclk_s & sclk_q_ff & ~cs_n_s & ~cs_n_q_ff; // [RULE11] [RULE10]
	assign cs_fall = ~cs_n_s & cs_n_q_ff;
	assign cs_rise = cs_n_s & ~cs_n_q_ff;
	assign xfer_ok = cs_rise & got_bits_ff & (bit_cnt_ff == 3'h0); // [RULE16]

	// shift register: status load on select, first-in first-out shifting
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			shift_ff <= '0;
		end else if (cs_fall) begin
			shift_ff <= status_word; // [RULE15]
		end else if (sclk_fall) begin
			shift_ff <= {shift_ff[CMD_BITS-2:0], si_s}; // [RULE6] [RULE8] [RULE9]
		end
	end

	// serial output bit and its enable
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_spi_so <= 1'b0;
			o_spi_so_oe <= 1'b0;
		end else begin
			o_spi_so_oe <= ~cs_n_s; // [RULE11]
			if (cs_fall) begin
				o_spi_so <= status_word[CMD_BITS-1]; // [RULE8]
			end else if (sclk_rise) begin
				o_spi_so <= shift_ff[CMD_BITS-1]; // [RULE7] [RULE9]
			end
		end
	end

	// bit count modulo eight within one frame
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			bit_cnt_ff <= 3'h0;
			got_bits_ff <= 1'b0;
		end else if (cs_fall) begin
			bit_cnt_ff <= 3'h0;
			got_bits_ff <= 1'b0;
		end else if (sclk_fall) begin
			bit_cnt_ff <= bit_cnt_ff + 3'h1;
			got_bits_ff <= 1'b1;
		end
	end

	// latched word out to the user side
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_cmd_word <= '0;
			o_cmd_valid <= 1'b0;
		end else begin
			o_cmd_valid <= xfer_ok;
			if (xfer_ok) begin
				o_cmd_word <= shift_ff; // [RULE15]
			end
		end
	end

	logic [N_OUT-1:0] spi_on_ff;
	logic [2:0] low_sel_ff [N_OUT];
	logic high_sel_ff [N_OUT];
	logic [1:0] delay_sel_ff [N_OUT];
	logic guard_off_ff;

	// configuration written by valid words
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			spi_on_ff <= '0;
			guard_off_ff <= RST_GUARD_OFF;
			for (int c = 0; c < N_OUT; c++) begin
				low_sel_ff[c] <= RST_LOW_SEL;
				high_sel_ff[c] <= RST_HIGH_SEL;
				delay_sel_ff[c] <= RST_DELAY_SEL;
			end
		end else if (xfer_ok) begin
			if (addr_is(shift_ff, ADDR_OUT_CTRL)) begin
				spi_on_ff <= {shift_ff[F_ON1], shift_ff[F_ON0]};
			end
			if (addr_is(shift_ff, ADDR_TRIP_LEVEL)) begin
				high_sel_ff[shift_ff[F_CHAN]] <= shift_ff[F_HIGH_SEL]; // [RULE1]
				low_sel_ff[shift_ff[F_CHAN]] <= shift_ff[2:0]; // [RULE1]
			end
			if (addr_is(shift_ff, ADDR_TRIP_DELAY)) begin
				delay_sel_ff[shift_ff[F_CHAN]] <= shift_ff[1:0];
			end
			if (addr_is(shift_ff, ADDR_SUPPLY) && shift_ff[F_CHAN]) begin
				guard_off_ff <= shift_ff[F_GUARD_OFF];
			end
		end
	end

	logic uv_active;
	logic [N_OUT-1:0] on_w;
	logic [N_OUT-1:0] oc_latch_w;
	logic [N_OUT-1:0] uv_lock_w;
	logic [N_OUT-1:0] low_flag_w;
	logic [N_OUT-1:0] high_flag_w;

	// supply low counts only when guarded and above the reset level
	assign uv_active = ~guard_off_ff & supply_low_s & ~supply_reset_s; // [RULE5]

	// per-output trip, latch and drive logic
	for (genvar c = 0; c < N_OUT; c++) begin : g_ch
		logic [TMR_W-1:0] tmr_ff;
		logic oc_latch_ff, uv_lock_ff, on_ff, low_flag_ff, high_flag_ff;
		logic cmd, low_hit, high_hit, low_trip, high_trip;
		logic [LOW_LEVELS-1:0] low_lv;
		logic [HIGH_LEVELS-1:0] high_lv;

		assign cmd = spi_on_ff[c] | direct_s[c];
		assign low_lv = low_s[c*LOW_LEVELS +: LOW_LEVELS];
		assign high_lv = high_s[c*HIGH_LEVELS +: HIGH_LEVELS];
		assign low_hit = low_lv[low_sel_ff[c]]; // [RULE1]
		assign high_hit = high_lv[high_sel_ff[c]]; // [RULE1]
		assign low_trip = on_ff & low_hit & (tmr_ff >= LOW_TRIP_CYC[delay_sel_ff[c]]); // [RULE2]
		assign high_trip = on_ff & high_hit; // [RULE3]

		// time spent at or over the low level while on
		always_ff @(posedge i_clk) begin
			if (i_srst || !(on_ff && low_hit)) begin
				tmr_ff <= '0;
			end else if (tmr_ff != {TMR_W{1'b1}}) begin
				tmr_ff <= tmr_ff + TMR_W'(1);
			end
		end

		// overcurrent latch: trip sets, command off releases, set wins
		always_ff @(posedge i_clk) begin
			if (i_srst) begin
				oc_latch_ff <= 1'b0;
			end else if (low_trip || high_trip) begin
				oc_latch_ff <= 1'b1; // [RULE2] [RULE3]
			end else if (!cmd) begin
				oc_latch_ff <= 1'b0; // [RULE4]
			end
		end

		// supply low while commanded on locks the output until re-command
		always_ff @(posedge i_clk) begin
			if (i_srst) begin
				uv_lock_ff <= 1'b0;
			end else if (uv_active && cmd) begin
				uv_lock_ff <= 1'b1; // [RULE12]
			end else if (!cmd && !uv_active) begin
				uv_lock_ff <= 1'b0; // [RULE12] [RULE13]
			end
		end

		// switch drive
		always_ff @(posedge i_clk) begin
			if (i_srst) begin
				on_ff <= 1'b0;
			end else begin
				on_ff <= cmd & ~oc_latch_ff & ~low_trip & ~high_trip & ~uv_lock_ff & ~uv_active
					& ~supply_reset_s; // [RULE3] [RULE4] [RULE5]
			end
		end

		// sticky fault bits, cleared by a valid transfer, set wins
		always_ff @(posedge i_clk) begin
			if (i_srst) begin
				low_flag_ff <= 1'b0;
				high_flag_ff <= 1'b0;
			end else begin
				if (low_trip) begin
					low_flag_ff <= 1'b1;
				end else if (xfer_ok) begin
					low_flag_ff <= 1'b0; // [RULE14]
				end
				if (high_trip) begin
					high_flag_ff <= 1'b1;
				end else if (xfer_ok) begin
					high_flag_ff <= 1'b0; // [RULE14]
				end
			end
		end

		assign on_w[c] = on_ff;
		assign oc_latch_w[c] = oc_latch_ff;
		assign uv_lock_w[c] = uv_lock_ff;
		assign low_flag_w[c] = low_flag_ff;
		assign high_flag_w[c] = high_flag_ff;
	end

	assign o_out_on = on_w;

	// status returned on the next frame
	always_comb begin
		status_word = '0;
		status_word[S_LATCHED] = |oc_latch_w;
		status_word[S_SUPPLY_LOW] = o_supply_low_flag;
		status_word[S_HIGH_LSB +: 2] = high_flag_w;
		status_word[S_LOW_LSB +: 2] = low_flag_w;
		status_word[S_ON_LSB +: 2] = on_w;
	end

	// fault pin and supply low flag
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_fault_flag_n <= 1'b1;
			o_supply_low_flag <= 1'b0;
		end else begin
			o_fault_flag_n <= ~((|oc_latch_w) | (|uv_lock_w) | uv_active); // [RULE4] [RULE5] [RULE12] [RULE13]
			if (uv_active) begin
				o_supply_low_flag <= 1'b1; // [RULE5]
			end else if (xfer_ok) begin
				o_supply_low_flag <= 1'b0; // [RULE13] [RULE14]
			end
		end
	end
endmodule

// ==== verification/swfl_switch_fault_latch_assertions.sv ====
// port checker for the switch fault latch and serial port
`timescale 1ns/1ps
module swfl_checker
	import swfl_pkg::*;
#(
	parameter int unsigned N_OUT = NUM_OUTPUTS
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_srst,
	// serial port
	input wire logic i_spi_cs_n,
	input wire logic i_spi_sclk,
	input wire logic i_spi_si,
	input wire logic o_spi_so,
	input wire logic o_spi_so_oe,
	// switch side
	input wire logic [N_OUT-1:0] i_direct_on,
	input wire logic [N_OUT*LOW_LEVELS-1:0] i_low_trip_level,
	input wire logic [N_OUT*HIGH_LEVELS-1:0] i_high_trip_level,
	input wire logic i_supply_low_threshold,
	input wire logic i_supply_reset_threshold,
	input wire logic [N_OUT-1:0] o_out_on,
	input wire logic o_fault_flag_n,
	input wire logic o_supply_low_flag,
	input wire logic [CMD_BITS-1:0] o_cmd_word,
	input wire logic o_cmd_valid
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_srst);
	logic [3:0] cs_hi_ff;
	logic hi0;
	logic lo0;
	logic lo_q_ff;
	logic [9:0] lo_cnt_ff;
	// every high level or every low level of output 0 reached
	assign hi0 = &i_high_trip_level[1:0];
	assign lo0 = &i_low_trip_level[7:0];
	// cycles since chip select went high, saturating
	always_ff @(posedge i_clk) begin
		if (i_srst || !i_spi_cs_n) begin
			cs_hi_ff <= 4'h0;
		end else if (cs_hi_ff != 4'hF) begin
			cs_hi_ff <= cs_hi_ff + 4'h1;
		end
	end
	// previous level of lo0, for finding its rise
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			lo_q_ff <= 1'b0;
		end else begin
			lo_q_ff <= lo0;
		end
	end
	// cycles since lo0 rose with output 0 on and no high level, saturating, zero when idle
	always_ff @(posedge i_clk) begin
		if (i_srst || !lo0) begin
			lo_cnt_ff <= 10'h000;
		end else if (!lo_q_ff && o_out_on[0] && !(|i_high_trip_level[1:0])) begin
			lo_cnt_ff <= 10'h001;
		end else if (lo_cnt_ff != 10'h000 && lo_cnt_ff != 10'h3FF) begin
			lo_cnt_ff <= lo_cnt_ff + 10'h001;
		end
	end
	so_released_a: assert property (cs_hi_ff > 4'h5 |-> !o_spi_so_oe)
		else $error("serial output driven while deselected");
	so_driven_a: assert property ($fell(i_spi_cs_n) |-> ##[2:6] o_spi_so_oe)
		else $error("serial output not enabled after select");
	so_moves_a: assert property ($changed(o_spi_so) && o_spi_so_oe && $past(o_spi_so_oe) |-> $past(i_spi_sclk, 3))
		else $error("serial output moved without a clock rise");
	low_trip_a: assert property (lo_cnt_ff == 10'h17C |-> o_out_on[0] ##[1:40] !o_out_on[0])
		else $error("low trip delay wrong");
	high_trip_a: assert property (hi0 [*5] |-> !o_out_on[0])
		else $error("high trip did not switch off");
	trip_flag_a: assert property ((hi0 && i_direct_on[0]) [*8] |-> !o_fault_flag_n)
		else $error("fault flag not low on trip");
	stays_off_a: assert property ($fell(o_out_on[0]) ##0 (i_direct_on[0] && !i_supply_reset_threshold) [*8]
		|-> !o_out_on[0])
		else $error("latched output came back on");
	word_latch_a: assert property (o_cmd_valid |-> $past(i_spi_cs_n) && !$past(i_spi_cs_n, 8) ##1 !o_cmd_valid)
		else $error("word latched away from select rise");
	flag_cause_a: assert property ($rose(o_supply_low_flag) |-> $past(i_supply_low_threshold, 2))
		else $error("supply low flag without cause");
	below_reset_a: assert property (i_supply_reset_threshold [*5] |-> o_out_on == '0)
		else $error("output on below reset level");
	// main scenarios reached
	cover property (o_cmd_valid);
	cover property ($fell(o_fault_flag_n));
	cover property ($rose(o_supply_low_flag));
endmodule
bind swfl_switch_fault_latch swfl_checker #(.N_OUT(N_OUT)) swfl_checker_inst (.*);

// ==== verification/swfl_host_model.sv ====
// serial bus master standing in for the host controller
`timescale 1ns/1ps
module swfl_host_model (
	// serial port pins
	output logic o_cs_n,
	output logic o_sclk,
	output logic o_si,
	input wire logic i_so
);
	// idle: deselected, clock parked low, data at its pull-down level
	initial begin
		o_cs_n = 1'b1;
		o_sclk = 1'b0;
		o_si = 1'b0;
	end
	// one framed transfer of nbits, so read late in each low phase
	task automatic xfer(input int nbits, input logic [15:0] din, output logic [15:0] dout);
		dout = 16'h0000;
		#1.2; // step off the bench clock edge
		o_cs_n = 1'b0; // clock is low here
		#30;
		for (int i = nbits - 1; i >= 0; i--) begin
			o_si = din[i]; // msb first
			o_sclk = 1'b1;
			#24;
			o_sclk = 1'b0;
			#24;
			dout[i] = i_so;
		end
		o_si = 1'b0;
		o_cs_n = 1'b1;
		#30;
	endtask
	// clock and data wiggled while deselected
	task automatic noise(input logic [7:0] pat);
		#1.2; // step off the bench clock edge
		for (int i = 7; i >= 0; i--) begin
			o_si = pat[i];
			o_sclk = 1'b1;
			#24;
			o_sclk = 1'b0;
			#24;
		end
		o_si = 1'b0;
	endtask
endmodule

// ==== verification/swfl_switch_fault_latch_test.sv ====
// self-checking bench for the switch fault latch and its serial port
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_errors++; $display("BAD %0t %h %h", $time, g, e); end end
module swfl_switch_fault_latch_test
	import swfl_pkg::*;
;
	logic i_clk, i_srst, i_spi_cs_n, i_spi_sclk, i_spi_si, o_spi_so, o_spi_so_oe, o_cmd_valid;
	logic i_supply_low_threshold, i_supply_reset_threshold, o_fault_flag_n, o_supply_low_flag;
	logic [1:0] i_direct_on, o_out_on;
	logic [15:0] i_low_trip_level, rd;
	logic [3:0] i_high_trip_level;
	logic [7:0] o_cmd_word, wa, wb;
	int n_errors = 0, comparisons = 0, n_valid = 0, seed = 40, exp_valid = 0;
	// design and host
	swfl_switch_fault_latch swfl_switch_fault_latch_inst (.*);
	// a released output shows the inverse, so a late enable reads wrong
	swfl_host_model swfl_host_model_inst (
		.o_cs_n(i_spi_cs_n),
		.o_sclk(i_spi_sclk),
		.o_si(i_spi_si),
		.i_so(o_spi_so_oe ? o_spi_so : ~o_spi_so)
	);
	// 200 MHz clock
	initial begin
		i_clk = 1'b0;
		forever #2.5 i_clk = ~i_clk;
	end
	// counts latched command words
	always @(posedge i_clk) begin
		if (o_cmd_valid === 1'b1) begin
			n_valid <= n_valid + 1;
		end
	end
	task automatic complete_run();
		$display("compares %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// waits for the switch drive to reach v, gives up after lim cycles
	task automatic wait_out(input logic [1:0] v, input int lim);
		repeat (lim) if (o_out_on !== v) @(posedge i_clk);
		if (o_out_on !== v) begin
			n_errors++;
			$display("BAD %0t %h %h", $time, o_out_on, v);
			complete_run();
		end
	endtask
	// one frame; a bit queue models the pass-through path, a count the accepted words
	task automatic frame(input int n, input logic [15:0] d);
		logic q[$];
		logic b;
		for (int i = n - 1; i >= 8; i--) begin
			q.push_back(d[i]);
		end
		swfl_host_model_inst.xfer(n, d, rd);
		if (n > 0 && n % 8 == 0) begin
			exp_valid++;
		end
		repeat (8) @(posedge i_clk);
		for (int i = n - 9; i >= 0; i--) begin
			b = q.pop_front();
			`CHK(rd[i], b)
		end
		`CHK(n_valid, exp_valid)
	endtask
	initial begin
		i_srst = 1'b1;
		i_direct_on = 2'b00;
		i_low_trip_level = 16'h0000;
		i_high_trip_level = 4'h0;
		i_supply_low_threshold = 1'b0;
		i_supply_reset_threshold = 1'b0;
		repeat (8) @(posedge i_clk);
		i_srst <= 1'b0;
		repeat (4) @(posedge i_clk);
		`CHK({o_out_on, o_fault_flag_n, o_supply_low_flag, o_cmd_word, o_spi_so_oe}, 13'h0400)
		// serial writes, chained words, short frame and deselected noise
		frame(8, 16'h0011);
		`CHK({o_out_on, rd[7:0]}, 10'h100)
		wa = 8'($random(seed)) | 8'h70;
		wb = 8'($random(seed)) | 8'h70;
		frame(16, {wa, wb});
		`CHK(rd, {8'h01, wa})
		`CHK(o_cmd_word, wb)
		frame(12, 16'h0A10);
		swfl_host_model_inst.noise(8'h10);
		repeat (8) @(posedge i_clk);
		`CHK({o_cmd_word, o_out_on, o_spi_so_oe, 8'(n_valid)}, {wb, 3'b010, 8'h02})
		frame(8, 16'h0010);
		`CHK(o_out_on, 2'h0)
		$display("serial done");
		// high level 1 selected: level 0 alone must not trip
		frame(8, 16'h0028);
		i_direct_on <= 2'b01;
		wait_out(2'h1, 10);
		i_high_trip_level <= 4'h1;
		repeat (20) @(posedge i_clk);
		`CHK(o_out_on, 2'h1)
		i_high_trip_level <= 4'h3;
		wait_out(2'h0, 10);
		repeat (20) @(posedge i_clk);
		`CHK({o_out_on, o_fault_flag_n}, 3'b000)
		frame(8, 16'h0000);
		`CHK(rd[7:0], 8'h90)
		frame(8, 16'h0000);
		`CHK(rd[7:0], 8'h80)
		i_high_trip_level <= 4'h0;
		repeat (8) @(posedge i_clk);
		`CHK(o_out_on, 2'h0)
		i_direct_on <= 2'b00;
		repeat (8) @(posedge i_clk);
		`CHK(o_fault_flag_n, 1'b1)
		i_direct_on <= 2'b01;
		wait_out(2'h1, 10);
		$display("high trip done");
		// low level held past the delay latches off
		i_low_trip_level <= 16'h00FF;
		repeat (380) @(posedge i_clk);
		`CHK(o_out_on, 2'h1)
		wait_out(2'h0, 60);
		frame(8, 16'h0000);
		`CHK(rd[7:0], 8'h84)
		i_low_trip_level <= 16'h0000;
		i_direct_on <= 2'b00;
		repeat (8) @(posedge i_clk);
		i_direct_on <= 2'b01;
		wait_out(2'h1, 10);
		$display("low trip done");
		// second output with the next delay choice
		frame(8, 16'h00B1);
		i_direct_on <= 2'b11;
		wait_out(2'h3, 10);
		i_low_trip_level <= 16'h0100;
		repeat (980) @(posedge i_clk);
		`CHK(o_out_on, 2'h3)
		wait_out(2'h1, 60);
		frame(8, 16'h0000);
		`CHK(rd[7:0], 8'h89)
		i_low_trip_level <= 16'h0000;
		i_direct_on <= 2'b01;
		repeat (8) @(posedge i_clk);
		`CHK(o_out_on, 2'h1)
		// supply low with guard on, recovery while commanded
		i_supply_low_threshold <= 1'b1;
		wait_out(2'h0, 10);
		repeat (4) @(posedge i_clk);
		`CHK({o_fault_flag_n, o_supply_low_flag}, 2'b01)
		i_supply_low_threshold <= 1'b0;
		repeat (20) @(posedge i_clk);
		`CHK({o_out_on, o_fault_flag_n}, 3'b000)
		i_direct_on <= 2'b00;
		repeat (10) @(posedge i_clk);
		`CHK({o_fault_flag_n, o_supply_low_flag}, 2'b11)
		frame(8, 16'h0000);
		`CHK({rd[7:0], o_supply_low_flag}, 9'h080)
		// guard off: no report, off only below reset level
		frame(8, 16'h00E2);
		i_direct_on <= 2'b01;
		wait_out(2'h1, 10);
		i_supply_low_threshold <= 1'b1;
		repeat (20) @(posedge i_clk);
		`CHK({o_out_on, o_fault_flag_n, o_supply_low_flag}, 4'b0110)
		i_supply_reset_threshold <= 1'b1;
		wait_out(2'h0, 10);
		i_supply_reset_threshold <= 1'b0;
		i_supply_low_threshold <= 1'b0;
		wait_out(2'h1, 10);
		`CHK({o_out_on, o_fault_flag_n}, 3'b011)
		$display("supply done");
		complete_run();
	end
endmodule
